// ===== hdl/async_serial_port_dma.sv
`timescale 1ns/1ps
module async_serial_port_dma (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration
  input wire uart_pkg::cfg_type cfg,
  // transmit data
  input wire logic [8:0] txData,
  input wire logic txWrite,
  output logic txReady,
  // receive data
  output logic [8:0] rxData,
  output logic rxAvail,
  input wire logic rxRead,
  // status
  output logic rxParityErr,
  output logic rxFrameErr,
  output logic rxOverrun,
  output logic rxAddrMatch,
  // dma
  output logic dmaTxReq,
  output logic dmaRxReq,
  // line
  input wire logic rxd,
  output logic txd
);
  import uart_pkg::*;

  logic [15:0] div_r;
  logic tick;
  logic rxSync1_r;
  logic rxSync2_r;
  word_type txHold_r;
  logic shiftReady;
  word_type rxHold_r;
  shift_type rst_r;
  logic [3:0] rovs_r;
  logic [3:0] rbit_r;
  logic [8:0] rsh_r;
  logic rpar_r;
  logic rperr_r;
  logic [3:0] rNBits;
  logic rxDone;
  logic rxKeep;

  // shared 16x oversample tick for both directions
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 16'h0000;
    end else if (div_r == 16'h0000) begin
      div_r <= (cfg.divisor == 16'h0000) ? DIV_RESET - 16'h0001 : cfg.divisor - 16'h0001;
    end else begin
      div_r <= div_r - 16'h0001;
    end
  end
  assign tick = (div_r == 16'h0000);

  // pin input crosses into mclk domain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
    end else begin
      rxSync1_r <= rxd;
      rxSync2_r <= rxSync1_r;
    end
  end

  // transmit holding register
  assign txReady = !txHold_r.valid && !cfg.dmaMode;
  assign dmaTxReq = !txHold_r.valid && cfg.dmaMode;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txHold_r <= '0;
    end else if (txWrite && !txHold_r.valid) begin
      txHold_r <= '{data: txData, valid: 1'b1};
    end else if (txHold_r.valid && shiftReady) begin
      txHold_r.valid <= 1'b0;
    end
  end

  uart_tx txShift (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick),
    .cfg(cfg),
    .holdData(txHold_r.data),
    .holdValid(txHold_r.valid),
    .shiftReady(shiftReady),
    .txd(txd)
  );

  // receive shifter, sampled at mid-bit
  assign rNBits = cfg.nineBit ? 4'h9 : 4'(cfg.wordLen) + 4'h5;
  assign rxDone = tick && rovs_r == OVS_LAST && rst_r == SH_STOP;
  // in address mode data words are dropped until our address arrives
  assign rxKeep = !cfg.nineBit || rsh_r[8] || rxAddrMatch;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_r <= SH_IDLE;
      rovs_r <= 4'h0;
      rbit_r <= 4'h0;
      rsh_r <= 9'h000;
      rpar_r <= 1'b0;
      rperr_r <= 1'b0;
    end else if (tick) begin
      rovs_r <= rovs_r + 4'h1;
      case (rst_r)
        SH_IDLE: begin
          rovs_r <= 4'h0;
          if (!rxSync2_r) begin
            rst_r <= SH_START;
          end
        end
        SH_START: begin
          if (rovs_r == OVS_MID) begin
            rovs_r <= 4'h0;
            rbit_r <= 4'h0;
            rsh_r <= 9'h000;
            rpar_r <= 1'b0;
            rperr_r <= 1'b0;
            // glitch filter: a start bit gone by mid-bit is noise
            rst_r <= rxSync2_r ? SH_IDLE : SH_DATA;
          end
        end
        SH_DATA: begin
          if (rovs_r == OVS_LAST) begin
            rsh_r[rbit_r] <= rxSync2_r;
            rpar_r <= rpar_r ^ rxSync2_r;
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r + 4'h1 == rNBits) begin
              rst_r <= (!cfg.nineBit && cfg.parity != PAR_NONE) ? SH_PAR : SH_STOP;
            end
          end
        end
        SH_PAR: begin
          if (rovs_r == OVS_LAST) begin
            rperr_r <= (rpar_r ^ rxSync2_r) != (cfg.parity == PAR_ODD);
            rst_r <= SH_STOP;
          end
        end
        SH_STOP: begin
          // only the first stop bit is checked; a second one reads as idle
          if (rovs_r == OVS_LAST) begin
            rst_r <= SH_IDLE;
          end
        end
        default: begin
          rst_r <= SH_IDLE;
        end
      endcase
    end
  end

  // receive holding register
  assign rxAvail = rxHold_r.valid && !cfg.dmaMode;
  assign dmaRxReq = rxHold_r.valid && cfg.dmaMode;
  assign rxData = rxHold_r.data;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxHold_r <= '0;
    end else if (rxDone && rxKeep) begin
      rxHold_r <= '{data: rsh_r, valid: 1'b1};
    end else if (rxRead) begin
      rxHold_r.valid <= 1'b0;
    end
  end

  // error flags: a new event wins over the clearing read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxParityErr <= 1'b0;
      rxFrameErr <= 1'b0;
      rxOverrun <= 1'b0;
    end else if (rxDone && rxKeep) begin
      rxParityErr <= rperr_r;
      rxFrameErr <= !rxSync2_r;
      rxOverrun <= rxOverrun | (rxHold_r.valid && !rxRead);
    end else if (rxRead) begin
      rxParityErr <= 1'b0;
      rxFrameErr <= 1'b0;
      rxOverrun <= 1'b0;
    end
  end

  // address match latched from last address character
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxAddrMatch <= 1'b0;
    end else if (!cfg.nineBit) begin
      rxAddrMatch <= 1'b0;
    end else if (rxDone && rsh_r[8]) begin
      rxAddrMatch <= (rsh_r[7:0] == cfg.ownAddr);
    end
  end
endmodule

// ===== hdl/uart_pkg.sv
package uart_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 115200;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / (BAUD_DEFAULT * 16));
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [1:0] WLEN_RESET = 2'h3;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD = 2'h2
  } parity_type;

  typedef struct packed {
    logic [15:0] divisor;
    logic [1:0] wordLen;
    logic twoStop;
    parity_type parity;
    logic nineBit;
    logic [7:0] ownAddr;
    logic dmaMode;
  } cfg_type;

  typedef struct packed {
    logic [8:0] data;
    logic valid;
  } word_type;

  typedef enum logic [2:0] {
    SH_IDLE = 3'h0,
    SH_START = 3'h1,
    SH_DATA = 3'h3,
    SH_PAR = 3'h2,
    SH_STOP = 3'h6
  } shift_type;
endpackage

// ===== hdl/uart_tx.sv
`timescale 1ns/1ps
module uart_tx (
  // clock, reset, tick and configuration
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tick,
  input wire uart_pkg::cfg_type cfg,
  // holding side
  input wire logic [8:0] holdData,
  input wire logic holdValid,
  output logic shiftReady,
  // line
  output logic txd
);
  import uart_pkg::*;

  shift_type st_r;
  logic [8:0] sh_r;
  logic [3:0] ovs_r;
  logic [3:0] bit_r;
  logic stop2_r;
  logic par_r;
  logic [3:0] nBits;

  assign nBits = cfg.nineBit ? 4'h9 : 4'(cfg.wordLen) + 4'h5;
  assign shiftReady = (st_r == SH_IDLE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= SH_IDLE;
      sh_r <= 9'h000;
      ovs_r <= 4'h0;
      bit_r <= 4'h0;
      stop2_r <= 1'b0;
      par_r <= 1'b0;
      txd <= 1'b1;
    end else if (st_r == SH_IDLE) begin
      txd <= 1'b1;
      if (holdValid) begin
        sh_r <= holdData;
        st_r <= SH_START;
        ovs_r <= 4'h0;
        bit_r <= 4'h0;
        stop2_r <= 1'b0;
        par_r <= (cfg.parity == PAR_ODD);
        txd <= 1'b0;
      end
    end else if (tick) begin
      ovs_r <= ovs_r + 4'h1;
      if (ovs_r == OVS_LAST) begin
        case (st_r)
          SH_START, SH_DATA: begin
            if (st_r == SH_DATA) begin
              sh_r <= {1'b0, sh_r[8:1]};
              bit_r <= bit_r + 4'h1;
            end
            if (st_r == SH_DATA && bit_r + 4'h1 == nBits) begin
              if (!cfg.nineBit && cfg.parity != PAR_NONE) begin
                st_r <= SH_PAR;
                txd <= par_r ^ sh_r[0];
              end else begin
                st_r <= SH_STOP;
                txd <= 1'b1;
              end
            end else begin
              st_r <= SH_DATA;
              txd <= (st_r == SH_DATA) ? sh_r[1] : sh_r[0];
              if (st_r == SH_DATA) begin
                par_r <= par_r ^ sh_r[0];
              end
            end
          end
          SH_PAR: begin
            st_r <= SH_STOP;
            txd <= 1'b1;
          end
          SH_STOP: begin
            if (cfg.twoStop && !stop2_r) begin
              stop2_r <= 1'b1;
            end else begin
              st_r <= SH_IDLE;
            end
          end
          default: begin
            st_r <= SH_IDLE;
            txd <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== sim/async_serial_port_dma_asserts.sv
`timescale 1ns/1ps
module async_serial_port_dma_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // data side
  input wire uart_pkg::cfg_type cfg,
  input wire logic [8:0] txData,
  input wire logic [8:0] rxData,
  input wire logic txWrite,
  input wire logic txReady,
  input wire logic rxAvail,
  input wire logic rxRead,
  input wire logic dmaTxReq,
  input wire logic dmaRxReq,
  // status and line
  input wire logic rxParityErr,
  input wire logic rxFrameErr,
  input wire logic rxOverrun,
  input wire logic rxAddrMatch,
  input wire logic rxd,
  input wire logic txd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reset_idle: assert property ($rose(resetn) |-> txd) else $error("txd low after reset");
  a_start_len: assert property ($fell(txd) |-> (!txd) [*8]) else $error("short low bit");
  a_bit_stable: assert property ($changed(txd) |=> $stable(txd) [*8]) else $error("short bit");
  a_write_takes: assert property (txWrite && txReady |=> !txReady) else $error("write lost");
  a_dma_gate: assert property (cfg.dmaMode |-> !txReady && !rxAvail) else $error("pio in dma");
  a_req_gate: assert property (!cfg.dmaMode |-> !dmaTxReq && !dmaRxReq) else $error("dma req");
  a_dma_takes: assert property (txWrite && dmaTxReq |=> !dmaTxReq)
    else $error("dma write lost");
  a_avail_stands: assert property (rxAvail && !rxRead |=> rxAvail || cfg.dmaMode)
    else $error("rx word lost");
  a_overrun_held: assert property ($rose(rxOverrun) |-> rxAvail || dmaRxReq)
    else $error("overrun without word");
  a_addr_nine: assert property ($rose(rxAddrMatch) |-> cfg.nineBit) else $error("addr match");
endmodule
bind async_serial_port_dma async_serial_port_dma_asserts chk_i (.mclk, .resetn, .cfg, .txData,
  .rxData, .txWrite, .txReady, .rxAvail, .rxRead, .dmaTxReq, .dmaRxReq, .rxParityErr,
  .rxFrameErr, .rxOverrun, .rxAddrMatch, .rxd, .txd);

// ===== sim/remote_uart.sv
`timescale 1ns/1ps
module remote_uart
  import uart_pkg::*;
  #(parameter int BIT = 16) (
  // clock
  input wire logic mclk,
  // line
  output logic line
);
  // idle line rests at the pull-up level
  initial line = 1'b1;
  // bit length in mclk cycles, follows the divisor the bench sets
  int bitLen = BIT;
  function automatic logic [12:0] frm(input logic [8:0] d, input cfg_type c, output int n);
    logic [12:0] f;
    int nb;
    nb = c.nineBit ? 9 : 5 + c.wordLen;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[1+i] = d[i];
    n = nb + 1;
    if (!c.nineBit && c.parity != PAR_NONE) begin
      f[n] = ^(d & 9'((1 << nb) - 1)) ^ (c.parity == PAR_ODD);
      n++;
    end
    n += c.twoStop ? 2 : 1;
    return f;
  endfunction
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (bitLen) @(posedge mclk);
    end
    // restores idle after a corrupted stop bit, one edge before any next frame
    line <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic put(input logic [8:0] d, input cfg_type c, input logic [12:0] x);
    logic [12:0] f;
    int n;
    f = frm(d, c, n);
    send(f ^ x, n);
  endtask
endmodule

// ===== sim/async_serial_port_dma_bench.sv
`timescale 1ns/1ps
module async_serial_port_dma_bench;
  import uart_pkg::*;
  localparam int BIT = 16;
  logic mclk = 0, resetn = 0, txWrite = 0, rxRead = 0, rxd, txd;
  logic txReady, rxAvail, rxParityErr, rxFrameErr, rxOverrun, rxAddrMatch, dmaTxReq, dmaRxReq;
  logic [8:0] txData = '0, rxData;
  cfg_type cfg;
  int n_mismatch = 0, n_tests = 0, cyc = 0, bt = BIT;
  initial forever #5 mclk = ~mclk;
  async_serial_port_dma uut (.mclk, .resetn, .cfg, .txData, .txWrite, .txReady, .rxData,
    .rxAvail, .rxRead, .rxParityErr, .rxFrameErr, .rxOverrun, .rxAddrMatch, .dmaTxReq,
    .dmaRxReq, .rxd, .txd);
  remote_uart #(.BIT(BIT)) far (.mclk, .line(rxd));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] d);
    txData <= d;
    txWrite <= 1'b1;
    do @(posedge mclk); while ((txReady | dmaTxReq) !== 1'b1);
    txWrite <= 1'b0;
  endtask
  task automatic rd;
    rxRead <= 1'b1;
    @(posedge mclk);
    rxRead <= 1'b0;
    @(posedge mclk);
  endtask
  // second word queued behind the first, so its start bit must follow the stops at once
  task automatic txChk(input logic [8:0] a, input logic [8:0] b);
    int m;
    logic [12:0] f;
    wr(a);
    f = far.frm(a, cfg, m);
    fork
      begin
        @(posedge mclk);
        while ((txReady | dmaTxReq) !== 1'b1) @(posedge mclk);
        wr(b);
      end
      begin
        while (txd) @(posedge mclk);
        repeat (bt / 2) @(posedge mclk);
        for (int i = 0; i <= m; i++) begin
          chk(txd, (i < m) ? f[i] : 1'b0);
          repeat (bt) @(posedge mclk);
        end
      end
    join
    repeat (m * bt) @(posedge mclk);
  endtask
  task automatic rxChk(input logic [8:0] d, input logic [12:0] x, input logic pe, fe);
    logic [8:0] k;
    k = cfg.nineBit ? 9'h1FF : 9'((1 << (5 + cfg.wordLen)) - 1);
    far.put(d, cfg, x);
    chk(rxAvail, !cfg.dmaMode);
    chk(dmaRxReq, cfg.dmaMode);
    chk(rxData & k, d & k);
    chk(rxParityErr, pe);
    chk(rxFrameErr, fe);
    rd;
  endtask
  task automatic fmtLoop;
    for (int k = 0; k < 24; k++) begin
      cfg.wordLen <= k[1:0];
      cfg.twoStop <= k[2];
      cfg.parity <= parity_type'(k / 8);
      @(posedge mclk);
      fork
        txChk(9'(8'hA5 + k), 9'h0C3);
        rxChk(9'(8'h3C + 7 * k), 13'h0, 0, 0);
      join
    end
  endtask
  task automatic errScen;
    cfg.wordLen <= 2'h3;
    cfg.twoStop <= 1'b0;
    cfg.parity <= PAR_EVEN;
    @(posedge mclk);
    rxChk(9'h081, 13'h200, 1, 0);
    rxChk(9'h07E, 13'h400, 0, 1);
    far.put(9'h011, cfg, 13'h0);
    far.put(9'h022, cfg, 13'h0);
    chk(rxOverrun, 1);
    chk(rxData, 9'h022);
    rd;
    chk(rxOverrun, 0);
    chk(rxAvail, 0);
  endtask
  task automatic nineScen;
    cfg.nineBit <= 1'b1;
    cfg.ownAddr <= 8'h5A;
    @(posedge mclk);
    txChk(9'h1A5, 9'h0FF);
    far.put(9'h15A, cfg, 13'h0);
    chk(rxAddrMatch, 1);
    chk(rxAvail, 1);
    rd;
    rxChk(9'h033, 13'h0, 0, 0);
    far.put(9'h1A5, cfg, 13'h0);
    chk(rxAddrMatch, 0);
    chk(rxAvail, 1);
    rd;
    far.put(9'h044, cfg, 13'h0);
    chk(rxAvail, 0);
    cfg.nineBit <= 1'b0;
    cfg.dmaMode <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic dmaScen;
    chk(dmaTxReq, 1);
    chk(txReady, 0);
    txChk(9'h05A, 9'h0A5);
    rxChk(9'h0C3, 13'h0, 0, 0);
    // slower divider so the tick gating is exercised in both directions
    cfg.divisor <= 16'h0002;
    far.bitLen = 2 * BIT;
    bt = 2 * BIT;
    @(posedge mclk);
    txChk(9'h0E1, 9'h01E);
    rxChk(9'h09C, 13'h0, 0, 0);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d compares", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ceiling well above the roughly 11500 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    cfg = '0;
    cfg.divisor = 16'h0001;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk(txd, 1);
    chk(txReady, 1);
    fmtLoop;
    errScen;
    nineScen;
    dmaScen;
    end_of_test;
  end
endmodule
